// ### src/opm_pkg.sv
package opm_pkg;

  // ------------------------------------------------------------------
  // operating modes, gray coded along full-on, active, sleep, deep sleep
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OPM_FULL_ON    = 3'h0,
    OPM_ACTIVE     = 3'h1,
    OPM_SLEEP      = 3'h3,
    OPM_DEEP_SLEEP = 3'h2,
    OPM_HIBERNATE  = 3'h6
  } opm_mode_e;

  // ------------------------------------------------------------------
  // clock source switch sequence
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OPM_SW_RUN  = 2'h0,
    OPM_SW_GATE = 2'h1,
    OPM_SW_FLIP = 2'h3
  } opm_sw_e;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SWITCH_SETTLE_NS = 16;
  localparam int SWITCH_SETTLE_CYC =
    (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES      = 3;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam opm_mode_e RESET_MODE     = OPM_FULL_ON;
  localparam logic      RESET_SEL_PLL  = 1'b1;
  localparam logic      RESET_CLK_EN   = 1'b1;
  localparam logic      RESET_PLL_EN   = 1'b1;

endpackage

// ### src/opm_clk_switch.sv
`timescale 1ns/1ps
module opm_clk_switch
  import opm_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic want_pll,
  input  wire logic core_req,
  input  wire logic sys_req,
  output logic      sel_pll,
  output logic      core_en,
  output logic      sys_en,
  output logic      busy
);

  localparam int CW = $clog2(SWITCH_SETTLE_CYC + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SWITCH_SETTLE_CYC - 1);

  opm_sw_e       state;
  logic [CW-1:0] cnt;

  assign busy = (state != OPM_SW_RUN) || (want_pll != sel_pll);

  // ------------------------------------------------------------------
  // gate, settle, flip source, settle, ungate
  // ------------------------------------------------------------------
  // both clocks are held off across the flip so no short pulse leaks out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= OPM_SW_RUN;
      cnt   <= '0;
    end else begin
      unique case (state)
        OPM_SW_RUN: begin
          if (want_pll != sel_pll) begin // [RULE16]
            state <= OPM_SW_GATE;
            cnt   <= SETTLE_LAST;
          end
        end
        OPM_SW_GATE: begin
          if (cnt == '0) begin
            state <= OPM_SW_FLIP;
            cnt   <= SETTLE_LAST;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        OPM_SW_FLIP: begin
          if (cnt == '0) begin
            state <= OPM_SW_RUN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= OPM_SW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_pll <= RESET_SEL_PLL;
    end else if (state == OPM_SW_GATE && cnt == '0) begin
      sel_pll <= want_pll; // [RULE16]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_en <= RESET_CLK_EN;
      sys_en  <= RESET_CLK_EN;
    end else if (!busy) begin
      core_en <= core_req;
      sys_en  <= sys_req;
    end else begin
      core_en <= 1'b0; // [RULE16]
      sys_en  <= 1'b0;
    end
  end

  chk_switch_while_gated : assert property ( // [RULE16]
    @(posedge clk) disable iff (!reset_n)
    $changed(sel_pll) |-> !core_en && !sys_en ##1 !core_en && !sys_en)
    else $error("clock source flipped while a clock was enabled");

endmodule

// ### src/opm_power_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: five operating modes, chosen by a software mode request.
// RULE2: each peripheral clock is gated on its own use request.
// RULE3: full-on runs pll enabled, not bypassed, clocks from pll.
// RULE4: reset puts the device in full-on mode.
// RULE5: active keeps pll enabled but bypassed; clocks at reference rate.
// RULE6: active mode allows dma to l1 memory.
// RULE7: in active, the pll off bit turns off the pll control input.
// RULE8: software re-enables pll before asking full-on or sleep.
// RULE9: sleep stops core clock, keeps pll and system clock.
// RULE10: in sleep an enabled wakeup event samples the bypass bit.
// RULE11: wake to full-on if bypass clear, to active if set.
// RULE12: sleep refuses system dma to l1 memory.
// RULE13: deep sleep stops core and system clocks.
// RULE14: deep sleep leaves on rtc interrupt to active; reset gives full-on.
// RULE15: hibernate removes core power and clocks; wake starts reset sequence.
// RULE16: clock source changes are glitch free, clocks gated across the switch.
module opm_power_ctrl
  import opm_pkg::*;
#(
  parameter int NUM_WAKE   = 8,
  parameter int NUM_PERIPH = 16
)(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  mode_req_valid,
  input  wire logic [2:0]            mode_req,
  input  wire logic                  pll_off_bit,
  input  wire logic                  bypass_bit,
  input  wire logic [NUM_WAKE-1:0]   wakeup_enable_reg,
  input  wire logic [NUM_WAKE-1:0]   wake_event,
  input  wire logic                  rtc_irq,
  input  wire logic                  hib_wake,
  input  wire logic [NUM_PERIPH-1:0] periph_use,
  output opm_mode_e                  mode_state,
  output logic                       pll_enable,
  output logic                       pll_bypass,
  output logic                       core_clk_en,
  output logic                       sys_clk_en,
  output logic [NUM_PERIPH-1:0]      periph_clk_en,
  output logic                       core_power_on,
  output logic                       dma_l1_allow,
  output logic                       hw_reset_req,
  output logic                       req_refused
);

  localparam int AW = NUM_WAKE + 2;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic legal_mode(input logic [2:0] code);
    legal_mode = (code == OPM_FULL_ON) || (code == OPM_ACTIVE) ||
                 (code == OPM_SLEEP) || (code == OPM_DEEP_SLEEP) ||
                 (code == OPM_HIBERNATE);
  endfunction

  function automatic logic needs_pll(input logic [2:0] code);
    needs_pll = (code == OPM_FULL_ON) || (code == OPM_SLEEP);
  endfunction

  // ------------------------------------------------------------------
  // input synchronisers for wake sources from other domains
  // ------------------------------------------------------------------
  logic [AW-1:0] sync1;
  logic [AW-1:0] sync2;
  logic [AW-1:0] sync3;
  logic [AW-1:0] async_stable;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {hib_wake, rtc_irq, wake_event};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      async_stable <= '0;
    end else begin
      async_stable <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & async_stable);
    end
  end

  logic wake_hit;
  logic rtc_hit;
  logic hib_hit;

  assign wake_hit = |(async_stable[NUM_WAKE-1:0] & wakeup_enable_reg); // [RULE10]
  assign rtc_hit  = async_stable[NUM_WAKE];
  assign hib_hit  = async_stable[NUM_WAKE+1];

  // ------------------------------------------------------------------
  // mode state machine
  // ------------------------------------------------------------------
  opm_mode_e mode;
  logic      want_pll;
  logic      sw_busy;
  logic      sw_sel_pll;
  logic      sw_core_en;
  logic      sw_sys_en;
  logic      req_ok;
  logic      req_blocked;

  // requests are only taken while the core runs and no source switch is underway
  assign req_ok = mode_req_valid && !sw_busy && legal_mode(mode_req) &&
                  (mode == OPM_FULL_ON || mode == OPM_ACTIVE); // [RULE1]
  // a disabled pll cannot back full-on or sleep
  assign req_blocked = req_ok && needs_pll(mode_req) &&
                       (mode == OPM_ACTIVE) && pll_off_bit; // [RULE8]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= RESET_MODE; // [RULE4]
    end else begin
      unique case (mode)
        OPM_FULL_ON, OPM_ACTIVE: begin
          if (req_ok && !req_blocked) begin
            mode <= opm_mode_e'(mode_req); // [RULE1]
          end
        end
        OPM_SLEEP: begin
          if (wake_hit) begin
            mode <= bypass_bit ? OPM_ACTIVE : OPM_FULL_ON; // [RULE11]
          end
        end
        OPM_DEEP_SLEEP: begin
          if (rtc_hit) begin
            mode <= OPM_ACTIVE; // [RULE14]
          end
        end
        OPM_HIBERNATE: begin
          if (hib_hit) begin
            mode <= OPM_FULL_ON; // [RULE15]
          end
        end
        default: begin
          mode <= RESET_MODE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_refused <= 1'b0;
    end else begin
      req_refused <= (mode_req_valid && !req_ok) || req_blocked;
    end
  end

  // sleep and the low states keep whatever source was last selected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      want_pll <= RESET_SEL_PLL;
    end else if (mode == OPM_FULL_ON) begin
      want_pll <= 1'b1; // [RULE3]
    end else if (mode == OPM_ACTIVE) begin
      want_pll <= 1'b0; // [RULE5]
    end
  end

  // ------------------------------------------------------------------
  // clock source switch and gating
  // ------------------------------------------------------------------
  logic core_req;
  logic sys_req;

  assign core_req = (mode == OPM_FULL_ON) || (mode == OPM_ACTIVE); // [RULE9]
  assign sys_req  = core_req || (mode == OPM_SLEEP); // [RULE13]

  opm_clk_switch u_switch (
    .clk      (clk),
    .reset_n  (reset_n),
    .want_pll (want_pll),
    .core_req (core_req),
    .sys_req  (sys_req),
    .sel_pll  (sw_sel_pll),
    .core_en  (sw_core_en),
    .sys_en   (sw_sys_en),
    .busy     (sw_busy)
  );

  assign core_clk_en = sw_core_en;
  assign sys_clk_en  = sw_sys_en;

  // status copy of the source select, one cycle behind the mux itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_bypass <= !RESET_SEL_PLL;
    end else begin
      pll_bypass <= !sw_sel_pll; // [RULE5]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_clk_en <= '0;
    end else begin
      periph_clk_en <= periph_use & {NUM_PERIPH{sw_sys_en}}; // [RULE2]
    end
  end

  // ------------------------------------------------------------------
  // pll, power, dma and reset outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_enable <= RESET_PLL_EN;
    end else begin
      unique case (mode)
        OPM_FULL_ON:    pll_enable <= 1'b1; // [RULE3]
        OPM_ACTIVE:     pll_enable <= !pll_off_bit; // [RULE7]
        OPM_SLEEP:      pll_enable <= 1'b1; // [RULE9]
        OPM_DEEP_SLEEP: pll_enable <= 1'b0;
        OPM_HIBERNATE:  pll_enable <= 1'b0;
        default:        pll_enable <= RESET_PLL_EN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_power_on <= 1'b1;
      dma_l1_allow  <= 1'b1;
      mode_state    <= RESET_MODE;
    end else begin
      core_power_on <= (mode != OPM_HIBERNATE); // [RULE15]
      dma_l1_allow  <= (mode == OPM_FULL_ON) || (mode == OPM_ACTIVE); // [RULE6] [RULE12]
      mode_state    <= mode;
    end
  end

  // waking from hibernate restarts the system through the reset sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_reset_req <= 1'b0;
    end else begin
      hw_reset_req <= (mode == OPM_HIBERNATE) && hib_hit; // [RULE15]
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_held(opm_mode_e m);
    (mode == m) ##1 (mode == m);
  endsequence

  sequence s_active_off;
    (mode == OPM_ACTIVE) && pll_off_bit;
  endsequence

  chk_full_on_pll : assert property ( // [RULE3]
    @(posedge clk) disable iff (!reset_n)
    s_held(OPM_FULL_ON) ##0 !sw_busy |-> pll_enable && !pll_bypass)
    else $error("full-on without pll clock");

  chk_active_bypass : assert property ( // [RULE5]
    @(posedge clk) disable iff (!reset_n)
    s_held(OPM_ACTIVE) ##0 !sw_busy |-> pll_bypass)
    else $error("active mode not bypassed");

  chk_pll_off_active : assert property ( // [RULE7]
    @(posedge clk) disable iff (!reset_n)
    s_active_off ##1 (mode == OPM_ACTIVE) |-> !pll_enable)
    else $error("pll still enabled after pll off in active");

  chk_sleep_core_off : assert property ( // [RULE9]
    @(posedge clk) disable iff (!reset_n)
    s_held(OPM_SLEEP) ##0 !sw_busy |-> !core_clk_en && pll_enable && sys_clk_en)
    else $error("sleep clocks wrong");

  chk_wake_return : assert property ( // [RULE11]
    @(posedge clk) disable iff (!reset_n)
    (mode == OPM_SLEEP) && wake_hit |=>
      (mode == ($past(bypass_bit) ? OPM_ACTIVE : OPM_FULL_ON)))
    else $error("wrong return mode after sleep wakeup");

  chk_sleep_no_dma : assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    s_held(OPM_SLEEP) |-> !dma_l1_allow)
    else $error("dma allowed in sleep");

  chk_deep_clocks : assert property ( // [RULE13]
    @(posedge clk) disable iff (!reset_n)
    s_held(OPM_DEEP_SLEEP) ##1 (mode == OPM_DEEP_SLEEP) |->
      !core_clk_en && !sys_clk_en && periph_clk_en == '0)
    else $error("clock running in deep sleep");

  chk_rtc_exit : assert property ( // [RULE14]
    @(posedge clk) disable iff (!reset_n)
    (mode == OPM_DEEP_SLEEP) && rtc_hit |=> (mode == OPM_ACTIVE))
    else $error("rtc interrupt did not leave deep sleep");

  chk_hib_wake : assert property ( // [RULE15]
    @(posedge clk) disable iff (!reset_n)
    (mode == OPM_HIBERNATE) && hib_hit |=> hw_reset_req && (mode == OPM_FULL_ON)
      ##1 !hw_reset_req && core_power_on)
    else $error("hibernate wake did not start reset sequence");

  chk_periph_gate : assert property ( // [RULE2]
    @(posedge clk) disable iff (!reset_n)
    (periph_clk_en != '0) |-> $past(sw_sys_en) && ((periph_clk_en & ~$past(periph_use)) == '0))
    else $error("peripheral clock enabled without request or system clock");

  chk_refuse_no_pll : assert property ( // [RULE8]
    @(posedge clk) disable iff (!reset_n)
    req_blocked |=> req_refused && (mode == OPM_ACTIVE))
    else $error("full-on or sleep taken with pll off");

endmodule

// ### tb/opm_power_ctrl_test.sv
`timescale 1ns/1ps
module opm_power_ctrl_test
  import opm_pkg::*;
;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic        clk;
  logic        reset_n;
  logic        vld;
  logic [2:0]  req_code;
  logic        pll_off;
  logic        byp;
  logic [7:0]  wen;
  logic [7:0]  wev;
  logic        rtc;
  logic        hib;
  logic [15:0] puse;
  opm_mode_e   mode;
  logic        pen;
  logic        pbyp;
  logic        cen;
  logic        sen;
  logic [15:0] pclk;
  logic        pwr;
  logic        dma;
  logic        hwr;
  logic        refd;
  logic        cb;
  int          miscompares;
  int          total_checks;
  int          seed;
  int          k;

  opm_power_ctrl #(.NUM_WAKE(8), .NUM_PERIPH(16)) DUT (
    .clk(clk), .reset_n(reset_n), .mode_req_valid(vld), .mode_req(req_code),
    .pll_off_bit(pll_off), .bypass_bit(byp), .wakeup_enable_reg(wen),
    .wake_event(wev), .rtc_irq(rtc), .hib_wake(hib), .periph_use(puse),
    .mode_state(mode), .pll_enable(pen), .pll_bypass(pbyp), .core_clk_en(cen),
    .sys_clk_en(sen), .periph_clk_en(pclk), .core_power_on(pwr),
    .dma_l1_allow(dma), .hw_reset_req(hwr), .req_refused(refd)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // {pll_enable, pll_bypass, core_en, sys_en, power, dma}; b is the held source
  function automatic logic [5:0] expv(input logic [2:0] m, input logic b, input logic po);
    case (m)
      3'h0:    expv = 6'h2F;
      3'h1:    expv = {~po, 5'h1F};
      3'h3:    expv = {1'b1, b, 4'h6};
      3'h2:    expv = {1'b0, b, 4'h2};
      default: expv = {1'b0, b, 4'h0};
    endcase
  endfunction

  task automatic req(input logic [2:0] m, input logic r);
    logic s;
    vld = 1'b1;
    req_code = m;
    cyc(1);
    s = refd;
    vld = 1'b0;
    cyc(1);
    s = s | refd;
    chk("req_refused", {15'h0, r}, {15'h0, s});
  endtask

  // waits for the mode to settle; a source flip while the core or system clock is open is a glitch
  task automatic go(input logic [2:0] m, input int pulses);
    logic [5:0] e;
    logic [2:0] prev;
    logic       gl;
    int         hp;
    int         i;
    e = expv(m, cb, pll_off);
    gl = 1'b0;
    hp = 0;
    for (i = 0; i < 100 && !(mode === m && {pen, pbyp, cen, sen, pwr, dma} === e); i++) begin
      prev = {pbyp, cen, sen};
      cyc(1);
      if (hwr === 1'b1) hp++;
      if (pbyp !== prev[2] && (cen | sen | prev[1] | prev[0])) gl = 1'b1;
    end
    repeat (3) begin
      cyc(1);
      if (hwr === 1'b1) hp++;
    end
    chk("mode_state", {13'h0, m}, {13'h0, mode});
    chk("mode_outputs", {10'h0, e}, {10'h0, pen, pbyp, cen, sen, pwr, dma});
    chk("switch_glitch", 16'h0, {15'h0, gl});
    chk("hw_reset_pulses", pulses[15:0], hp[15:0]);
    puse = 16'($random(seed));
    cyc(2);
    chk("periph_clk_en", puse & {16{e[2]}}, pclk);
    $display("step to mode %0d done", m);
  endtask

  task automatic chk_rst();
    chk("reset_mode", 16'h0, {13'h0, mode});
    chk("reset_outputs", 16'h00BC, {8'h0, pen, pbyp, cen, sen, pwr, dma, hwr, refd});
    chk("reset_periph", 16'h0, pclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // watchdog, sized well beyond the whole sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("mismatch watchdog expected finish seen timeout");
    wrap_up();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h49510A29;
    miscompares = 0;
    total_checks = 0;
    reset_n = 1'b0;
    vld = 1'b0;
    req_code = 3'h0;
    pll_off = 1'b0;
    byp = 1'b0;
    wen = 8'h00;
    wev = 8'h00;
    rtc = 1'b0;
    hib = 1'b0;
    puse = 16'($random(seed));
    cb = 1'b0;
    cyc(12);
    chk_rst();
    reset_n = 1'b1;
    go(3'h0, 0);
    req(3'h1, 1'b0);
    req(3'h0, 1'b1);
    cb = 1'b1;
    go(3'h1, 0);
    pll_off = 1'b1;
    cyc(2);
    go(3'h1, 0);
    req(3'h0, 1'b1);
    req(3'h3, 1'b1);
    pll_off = 1'b0;
    cyc(2);
    req(3'h3, 1'b0);
    go(3'h3, 0);
    req(3'h1, 1'b1);
    // disabled wake sources and the rtc line must not end sleep
    wen = 8'h0F;
    wev = 8'hF0;
    rtc = 1'b1;
    cyc(10);
    chk("sleep_hold", {13'h0, 3'h3}, {13'h0, mode});
    rtc = 1'b0;
    byp = 1'b1;
    wev = 8'h04;
    go(3'h1, 0);
    // let the wake level drain out of the synchroniser before sleeping again
    wev = 8'h00;
    cyc(6);
    req(3'h3, 1'b0);
    go(3'h3, 0);
    byp = 1'b0;
    wev = 8'h01;
    cb = 1'b0;
    go(3'h0, 0);
    wev = 8'h00;
    for (k = 4; k < 8; k++) begin
      if (k != 6) req(k[2:0], 1'b1);
    end
    req(3'h2, 1'b0);
    go(3'h2, 0);
    rtc = 1'b1;
    cb = 1'b1;
    go(3'h1, 0);
    rtc = 1'b0;
    req(3'h6, 1'b0);
    go(3'h6, 0);
    hib = 1'b1;
    cb = 1'b0;
    go(3'h0, 1);
    hib = 1'b0;
    // reset in mid-switch must still land in full-on
    req(3'h1, 1'b0);
    cyc(3);
    reset_n = 1'b0;
    cyc(2);
    chk_rst();
    reset_n = 1'b1;
    go(3'h0, 0);
    wrap_up();
  end
endmodule
